// *** inc/tes_defines.svh ***
// Offsets, field positions, reset values and codes of the error status block
//
// Contract
// - Eight-bit read-only error register, index 06h, reset 00h
// - Host FIFO write during anticollision/auth sets bit7
// - Host FIFO write between last TX/RX bit sets bit7
// - Overheat sets bit6, antenna drivers switched off
// - Late counterpart RF field sets bit5 in active mode
// - Any write into full FIFO sets bit4
// - Collision sets bit3, receiver start-up clears it
// - Bit3 reads one at 212/424 kbit
// - CRC failure with checking enabled sets bit2
// - Parity failure at 106 kbit sets bit1
// - Bad start of frame at 106 sets bit0
// - Anticollision command with initiator bit sets bit0
// - Wrong byte count during authentication sets bit0
// - Too-close Miller pulses set bit0
// - Command start clears all flags but overheat
// - Host writes never change error flags
// - Any error flag sets error interrupt request
`ifndef TES_DEFINES_SVH
`define TES_DEFINES_SVH

`define TES_COMM_IRQ_IDX    6'h04
`define TES_ERR_STATUS_IDX  6'h06
`define TES_RX_CFG_IDX      6'h10
`define TES_ERR_STATUS_RST  8'h00
`define TES_COMM_IRQ_RST    8'h00
`define TES_RX_CFG_RST      10'h000

`define TES_BIT_WR_VIOL     7
`define TES_BIT_OVERHEAT    6
`define TES_BIT_FIELD_LATE  5
`define TES_BIT_OVERFLOW    4
`define TES_BIT_COLLISION   3
`define TES_BIT_CHECKSUM    2
`define TES_BIT_PARITY      1
`define TES_BIT_PROTOCOL    0

`define TES_IRQ_SET_BIT     7
`define TES_IRQ_ERR_BIT     1

`define TES_FRAME_ACTIVE    2'h1
`define TES_FRAME_SYNC      2'h2

`endif

// *** inc/tes_pkg.sv ***
// Types shared by the error status block
package tes_pkg;

  typedef enum logic [3:0] {
    TES_CMD_IDLE      = 4'h0,
    TES_CMD_AUTO_COLL = 4'h1,
    TES_CMD_CARD_AUTH = 4'h2,
    TES_CMD_OTHER     = 4'hF
  } tes_cmd_type;

  typedef enum logic [1:0] {
    TES_SPD_106 = 2'h0,
    TES_SPD_212 = 2'h1,
    TES_SPD_424 = 2'h2,
    TES_SPD_RSV = 2'h3
  } tes_speed_type;

  typedef struct packed {
    logic host_fifo_wr;
    logic int_fifo_wr;
    logic fifo_full;
    logic last_tx_bit;
    logic last_rx_bit;
    logic field_late;
    logic coll_det;
    logic crc_fail;
    logic parity_fail;
    logic sof_bad;
    logic byte_len_viol;
    logic auth_len_bad;
    logic miller_short;
    logic rx_startup;
  } tes_event_type;

  typedef struct packed {
    logic          initiator;
    logic          sync_detect_on;
    logic          rx_checksum_check_on;
    logic          active_mode;
    tes_speed_type speed;
    logic [1:0]    transmit_frame_style;
    logic [1:0]    receive_frame_style;
  } tes_cfg_type;

endpackage : tes_pkg

// *** verilog/tes_sync.sv ***
// Three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
`default_nettype none
module tes_sync (
  input  wire logic i_clk,   // System clock
  input  wire logic i_nrst,  // Async reset, active low
  input  wire logic i_level, // Asynchronous level
  output var  logic o_level  // Filtered level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_level;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change accepted only when stages two and three agree
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level <= 1'b0;
    end else if (s2_q == s3_q) begin
      o_level <= s3_q;
    end
  end

endmodule : tes_sync
`default_nettype wire

// *** verilog/tes_flag.sv ***
// Sticky error flag; a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module tes_flag (
  input  wire logic i_clk,  // System clock
  input  wire logic i_nrst, // Async reset, active low
  input  wire logic i_set,  // Hardware event
  input  wire logic i_clr,  // Clear event
  output var  logic o_q     // Flag value
);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_q <= 1'b0;
    end else if (i_set) begin
      o_q <= 1'b1;
    end else if (i_clr) begin
      o_q <= 1'b0;
    end
  end

endmodule : tes_flag
`default_nettype wire

// *** verilog/tes_top.sv ***
// Error status register bank with APB slave
`timescale 1ns/1ps
`default_nettype none
`include "tes_defines.svh"
module tes_top (
  input  wire logic                   I_CLK_SYS,      // 100 MHz system clock
  input  wire logic                   I_NRST,         // Async reset, active low
  input  wire logic                   I_PSEL,         // APB select
  input  wire logic                   I_PENABLE,      // APB access phase
  input  wire logic                   I_PWRITE,       // APB write
  input  wire logic [7:0]             I_PADDR,        // APB byte address
  input  wire logic [31:0]            I_PWDATA,       // APB write data
  output var  logic [31:0]            O_PRDATA,       // APB read data
  output var  logic                   O_PREADY,       // APB ready
  output var  logic                   O_PSLVERR,      // APB error
  input  wire logic [3:0]             I_CMD_CODE,     // Command executing
  input  wire logic                   I_CMD_START,    // Command start pulse
  input  wire tes_pkg::tes_event_type I_EVT,          // Event pulses
  input  wire logic                   I_OVERHEAT,     // Temperature sensor pin
  output var  logic [7:0]             O_ERROR_STATUS, // Stored error flags, collision bit not forced
  output var  logic                   O_ERR_IRQ_FLAG, // Error interrupt request
  output var  logic                   O_ANTENNA_OFF   // Antenna driver shutdown
);
  import tes_pkg::*;

  function automatic logic [7:0] addr_of(input logic [5:0] idx);
    addr_of = {idx, 2'b00};
  endfunction : addr_of

  function automatic logic is_106(input tes_speed_type spd);
    is_106 = (spd == TES_SPD_106);
  endfunction : is_106

  tes_cfg_type cfg_q;
  tes_cmd_type cmd;
  logic        overheat_lvl;
  logic        rf_window_q;
  logic [7:0]  flag_q;
  logic [7:0]  flag_set;
  logic [7:0]  flag_clr;
  logic [7:0]  status_rd;
  logic        irq_err_q;
  logic [31:0] prdata_q;
  logic        setup;
  logic        access;
  logic        wr_access;
  logic        mapped;
  logic        hit_irq;
  logic        hit_err;
  logic        hit_cfg;
  logic        auto_coll_run;
  logic        card_auth_run;
  logic        field_check_on;
  logic        irq_wr_set;
  logic        irq_wr_clr;

  assign cmd = tes_cmd_type'(I_CMD_CODE);

  // APB decode; zero wait states, read data captured in setup cycle
  assign setup     = I_PSEL & ~I_PENABLE;
  assign access    = I_PSEL & I_PENABLE;
  assign wr_access = access & I_PWRITE;
  assign hit_irq   = (I_PADDR == addr_of(`TES_COMM_IRQ_IDX));
  assign hit_err   = (I_PADDR == addr_of(`TES_ERR_STATUS_IDX));
  assign hit_cfg   = (I_PADDR == addr_of(`TES_RX_CFG_IDX));
  assign mapped    = hit_irq | hit_err | hit_cfg;

  assign O_PREADY  = access;
  assign O_PSLVERR = access & ~mapped;
  assign O_PRDATA  = prdata_q;

  // Sensor runs outside the digital timing; filter before use
  tes_sync u_overheat_sync (
    .i_clk   (I_CLK_SYS),
    .i_nrst  (I_NRST),
    .i_level (I_OVERHEAT),
    .o_level (overheat_lvl)
  );

  // Receive/framing configuration written by software
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg_q <= tes_cfg_type'(`TES_RX_CFG_RST);
    end else if (wr_access && hit_cfg) begin
      cfg_q <= tes_cfg_type'(I_PWDATA[9:0]);
    end
  end

  assign auto_coll_run = (cmd == TES_CMD_AUTO_COLL);
  assign card_auth_run = (cmd == TES_CMD_CARD_AUTH);

  // Timing check needs active mode and one side framed as active
  assign field_check_on = cfg_q.active_mode &&
                          ((cfg_q.receive_frame_style == `TES_FRAME_ACTIVE) ||
                           (cfg_q.transmit_frame_style == `TES_FRAME_ACTIVE));

  // Span from last sent bit to last received bit
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      rf_window_q <= 1'b0;
    end else if (I_EVT.last_tx_bit) begin
      rf_window_q <= 1'b1;
    end else if (I_EVT.last_rx_bit || I_CMD_START) begin
      rf_window_q <= 1'b0;
    end
  end

  // Set terms of each flag
  always_comb begin
    flag_set = 8'h00;
    flag_set[`TES_BIT_WR_VIOL] = I_EVT.host_fifo_wr &&
                                 (auto_coll_run || card_auth_run ||
                                  rf_window_q);
    flag_set[`TES_BIT_OVERHEAT] = overheat_lvl;
    flag_set[`TES_BIT_FIELD_LATE] = I_EVT.field_late && field_check_on;
    flag_set[`TES_BIT_OVERFLOW] = I_EVT.fifo_full &&
                                  (I_EVT.host_fifo_wr || I_EVT.int_fifo_wr);
    flag_set[`TES_BIT_COLLISION] = I_EVT.coll_det;
    flag_set[`TES_BIT_CHECKSUM] = I_EVT.crc_fail &&
                                  cfg_q.rx_checksum_check_on;
    flag_set[`TES_BIT_PARITY] = I_EVT.parity_fail && is_106(cfg_q.speed);
    flag_set[`TES_BIT_PROTOCOL] =
        (I_EVT.sof_bad && is_106(cfg_q.speed)) ||
        (I_EVT.byte_len_viol && cfg_q.sync_detect_on &&
         !is_106(cfg_q.speed) &&
         (cfg_q.active_mode ||
          (cfg_q.receive_frame_style == `TES_FRAME_SYNC))) ||
        (auto_coll_run && cfg_q.initiator) ||
        (I_EVT.auth_len_bad && card_auth_run) ||
        I_EVT.miller_short;
  end

  // Clear terms; software has no path here
  always_comb begin
    flag_clr = {8{I_CMD_START}};
    flag_clr[`TES_BIT_OVERHEAT] = 1'b0;
    flag_clr[`TES_BIT_COLLISION] = I_CMD_START || I_EVT.rx_startup;
    flag_clr[`TES_BIT_CHECKSUM] = I_CMD_START || I_EVT.rx_startup;
    flag_clr[`TES_BIT_PARITY] = I_CMD_START || I_EVT.rx_startup;
    flag_clr[`TES_BIT_PROTOCOL] = I_CMD_START || I_EVT.rx_startup;
  end

  // Sticky cells; reads do not touch them
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      tes_flag u_flag (
        .i_clk  (I_CLK_SYS),
        .i_nrst (I_NRST),
        .i_set  (flag_set[gi]),
        .i_clr  (flag_clr[gi]),
        .o_q    (flag_q[gi])
      );
    end
  endgenerate

  // Collision not meaningful above 106 kbit, so it reads set there
  always_comb begin
    status_rd = flag_q;
    status_rd[`TES_BIT_COLLISION] = flag_q[`TES_BIT_COLLISION] ||
                                    !is_106(cfg_q.speed);
  end

  assign O_ERROR_STATUS = flag_q;
  // Antenna stays off while the overheat flag is held
  assign O_ANTENNA_OFF  = flag_q[`TES_BIT_OVERHEAT];

  // Error request bit: bit 7 of a write selects set or clear of marked bits
  assign irq_wr_set = wr_access && hit_irq &&
                      I_PWDATA[`TES_IRQ_SET_BIT] && I_PWDATA[`TES_IRQ_ERR_BIT];
  assign irq_wr_clr = wr_access && hit_irq &&
                      !I_PWDATA[`TES_IRQ_SET_BIT] && I_PWDATA[`TES_IRQ_ERR_BIT];

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      irq_err_q <= 1'(`TES_COMM_IRQ_RST >> `TES_IRQ_ERR_BIT);
    end else if ((|flag_q) || irq_wr_set) begin
      irq_err_q <= 1'b1;
    end else if (irq_wr_clr) begin
      irq_err_q <= 1'b0;
    end
  end

  assign O_ERR_IRQ_FLAG = irq_err_q;

  // Read data latched in the setup cycle, presented in the access cycle
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !I_PWRITE) begin
      prdata_q <= 32'h0000_0000;
      if (hit_err) begin
        prdata_q[7:0] <= status_rd;
      end else if (hit_irq) begin
        prdata_q[`TES_IRQ_ERR_BIT] <= irq_err_q;
      end else if (hit_cfg) begin
        prdata_q[9:0] <= cfg_q;
      end
    end
  end

endmodule : tes_top
`default_nettype wire

// *** test/tes_host_model.sv ***
// Host controller model: APB master for the error status block
`timescale 1ns/1ps
`default_nettype none
module tes_host_model (
  input  wire logic        i_clk,     // System clock
  output var  logic        o_psel,    // APB select
  output var  logic        o_penable, // APB access phase
  output var  logic        o_pwrite,  // APB direction
  output var  logic [7:0]  o_paddr,   // APB byte address
  output var  logic [31:0] o_pwdata,  // APB write data
  input  wire logic [31:0] i_prdata,  // APB read data
  input  wire logic        i_pready,  // APB ready
  input  wire logic        i_pslverr  // APB error
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // Address and data inverted once released, so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    rd = i_prdata;
    er = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer
endmodule : tes_host_model
`default_nettype wire

// *** test/tes_checker.sv ***
// Port assertions for the error status block
`timescale 1ns/1ps
`default_nettype none
module tes_checker (
  input wire logic                   I_CLK_SYS,      // Clock
  input wire logic                   I_NRST,         // Reset, active low
  input wire logic                   I_PSEL,         // APB select
  input wire logic                   I_PENABLE,      // APB access
  input wire logic                   I_PWRITE,       // APB direction
  input wire logic [7:0]             I_PADDR,        // APB address
  input wire logic [31:0]            I_PWDATA,       // APB write data
  input wire logic [31:0]            O_PRDATA,       // APB read data
  input wire logic                   O_PREADY,       // APB ready
  input wire logic                   O_PSLVERR,      // APB error
  input wire logic [3:0]             I_CMD_CODE,     // Command code
  input wire logic                   I_CMD_START,    // Command start
  input wire tes_pkg::tes_event_type I_EVT,          // Events
  input wire logic                   I_OVERHEAT,     // Overheat pin
  input wire logic [7:0]             O_ERROR_STATUS, // Flags
  input wire logic                   O_ERR_IRQ_FLAG, // Error request
  input wire logic                   O_ANTENNA_OFF   // Antenna off
);
  import tes_pkg::*;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  chk_coll_set: assert property (I_EVT.coll_det |=> O_ERROR_STATUS[3])
    else $error("collision flag not set");
  chk_start_clear: assert property (I_CMD_START && I_EVT == '0 && I_CMD_CODE != 4'h1
    |=> {O_ERROR_STATUS[7], O_ERROR_STATUS[5:0]} == 7'h00) else $error("command start left flags");
  chk_overheat_keep: assert property (O_ERROR_STATUS[6] |=> O_ERROR_STATUS[6])
    else $error("overheat flag dropped");
  chk_antenna_off: assert property (I_OVERHEAT [*6] |-> O_ANTENNA_OFF)
    else $error("antenna not shut down on overheat");
  chk_irq_follow: assert property (|O_ERROR_STATUS |=> O_ERR_IRQ_FLAG)
    else $error("error request missing");
  chk_auth_len: assert property (I_EVT.auth_len_bad && I_CMD_CODE == 4'h2 |=> O_ERROR_STATUS[0])
    else $error("auth length fault missed");
  chk_wr_viol: assert property (I_EVT.host_fifo_wr && I_CMD_CODE inside {4'h1, 4'h2} |=> O_ERROR_STATUS[7])
    else $error("write violation missed");
  chk_overflow_set: assert property (I_EVT.fifo_full && (I_EVT.host_fifo_wr || I_EVT.int_fifo_wr)
    |=> O_ERROR_STATUS[4]) else $error("overflow missed");
  chk_startup_clr: assert property (I_EVT.rx_startup && I_EVT[7:1] == 7'h00 && I_CMD_CODE != 4'h1
    |=> O_ERROR_STATUS[3:0] == 4'h0) else $error("start-up left receive flags");
  chk_flags_hold: assert property (!I_CMD_START && !I_EVT.rx_startup
    |=> (O_ERROR_STATUS & $past(O_ERROR_STATUS)) == $past(O_ERROR_STATUS)) else $error("flag lost");
  chk_unmapped_err: assert property (I_PSEL && I_PENABLE && !(I_PADDR inside {8'h10, 8'h18, 8'h40})
    |-> O_PREADY && O_PSLVERR && O_PRDATA == 32'h0) else $error("unmapped access not refused");
  cover property (I_EVT.coll_det);
  cover property (I_CMD_START && O_ERROR_STATUS[6]);
  cover property (O_PSLVERR);
endmodule : tes_checker
bind tes_top tes_checker i_tes_checker (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CMD_CODE(I_CMD_CODE),
  .I_CMD_START(I_CMD_START), .I_EVT(I_EVT), .I_OVERHEAT(I_OVERHEAT), .O_ERROR_STATUS(O_ERROR_STATUS),
  .O_ERR_IRQ_FLAG(O_ERR_IRQ_FLAG), .O_ANTENNA_OFF(O_ANTENNA_OFF));
`default_nettype wire

// *** test/tes_top_tb.sv ***
// Self-checking bench for the error status block
`timescale 1ns/1ps
`default_nettype none
module tes_top_tb;
  import tes_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, psel, pen, pwr, pready, pslverr, start = 1'b0, heat = 1'b0, irq, ant;
  logic [7:0] paddr, status, exp_flags = 8'h00;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] cmd = 4'h0;
  logic [9:0] cur_cfg = 10'h000;
  logic er;
  tes_event_type evt = '0;
  integer seed = 63, mismatches = 0, check_count = 0, cycles = 0;
  always #5 clk = ~clk;
  tes_host_model u_host (.i_clk(clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr),
    .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
  tes_top i_tes_top (.I_CLK_SYS(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_CMD_CODE(cmd), .I_CMD_START(start), .I_EVT(evt), .I_OVERHEAT(heat), .O_ERROR_STATUS(status),
    .O_ERR_IRQ_FLAG(irq), .O_ANTENNA_OFF(ant));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cfg(input logic [9:0] v);
    u_host.xfer(1'b1, 8'h40, {22'h0, v}, rd, er);
    cur_cfg = v;
    u_host.xfer(1'b0, 8'h40, 32'h0, rd, er);
    chk("config", {22'h0, v}, rd);
  endtask : cfg
  // One pulse, then a random host write to the flags and a read-back, which must both be harmless
  task automatic step(input logic [3:0] c, input logic [13:0] ev, input logic st, input logic [7:0] m);
    @(posedge clk);
    cmd <= c;
    evt <= tes_event_type'(ev);
    start <= st;
    @(posedge clk);
    cmd <= 4'h0;
    evt <= '0;
    start <= 1'b0;
    if (st) exp_flags = exp_flags & 8'h40;
    if (ev[0]) exp_flags = exp_flags & 8'hF0;
    exp_flags = exp_flags | m;
    @(posedge clk);
    chk("status", {24'h0, exp_flags}, {24'h0, status});
    u_host.xfer(1'b1, 8'h18, $random(seed), rd, er);
    u_host.xfer(1'b0, 8'h18, 32'h0, rd, er);
    chk("read", {24'h0, exp_flags | (cur_cfg[5:4] != 2'h0 ? 8'h08 : 8'h00)}, rd);
    chk("status held", {24'h0, exp_flags}, {24'h0, status});
  endtask : step
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    u_host.xfer(1'b0, 8'h18, 32'h0, rd, er);
    chk("reset value", 32'h0, rd);
    u_host.xfer(1'b0, 8'h44, 32'h0, rd, er);
    chk("unmapped", 32'h1, {31'h0, er});
    step(4'h0, 14'h0080, 1'b0, 8'h08);
    chk("irq", 32'h1, {31'h0, irq});
    u_host.xfer(1'b0, 8'h10, 32'h0, rd, er);
    chk("irq reg", 32'h2, rd);
    step(4'h0, 14'h0001, 1'b0, 8'h00);
    step(4'h0, 14'h0040, 1'b0, 8'h00);
    cfg(10'h080);
    step(4'h0, 14'h0040, 1'b0, 8'h04);
    step(4'h0, 14'h0000, 1'b1, 8'h00);
    u_host.xfer(1'b1, 8'h10, 32'h2, rd, er);
    @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    cfg(10'h000);
    step(4'h0, 14'h0020, 1'b0, 8'h02);
    step(4'h0, 14'h0010, 1'b0, 8'h01);
    step(4'h0, 14'h0001, 1'b0, 8'h00);
    step(4'h0, 14'h0002, 1'b0, 8'h01);
    step(4'h2, 14'h0004, 1'b1, 8'h01);
    step(4'h0, 14'h0004, 1'b1, 8'h00);
    cfg(10'h010);
    step(4'h0, 14'h0030, 1'b0, 8'h00);
    cfg(10'h150);
    step(4'h0, 14'h0008, 1'b0, 8'h01);
    cfg(10'h041);
    step(4'h0, 14'h0100, 1'b1, 8'h20);
    cfg(10'h001);
    step(4'h0, 14'h0100, 1'b1, 8'h00);
    cfg(10'h200);
    step(4'h1, 14'h0000, 1'b1, 8'h01);
    cfg(10'h000);
    step(4'h1, 14'h2000, 1'b1, 8'h80);
    step(4'hF, 14'h2000, 1'b1, 8'h00);
    step(4'h0, 14'h0400, 1'b0, 8'h00);
    step(4'h0, 14'h2000, 1'b0, 8'h80);
    step(4'h0, 14'h0200, 1'b1, 8'h00);
    step(4'h0, 14'h2000, 1'b0, 8'h00);
    step(4'h0, 14'h1800, 1'b0, 8'h10);
    step(4'h0, 14'h2800, 1'b1, 8'h10);
    heat <= 1'b1;
    for (int k = 0; k < 20 && status[6] !== 1'b1; k++) @(posedge clk);
    exp_flags = exp_flags | 8'h40;
    chk("antenna off", 32'h1, {31'h0, ant});
    step(4'h0, 14'h0000, 1'b1, 8'h00);
    heat <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset flags", 32'h0, {24'h0, status});
    chk("reset antenna", 32'h0, {31'h0, ant});
    chk("reset irq", 32'h0, {31'h0, irq});
    nrst <= 1'b1;
    exp_flags = 8'h00;
    step(4'h0, 14'h0080, 1'b0, 8'h08);
    end_of_test();
  end
endmodule : tes_top_tb
`default_nettype wire
